// ### logic/upt_port_tuning_regs.sv
`timescale 1ns/10ps
`default_nettype none
module upt_port_tuning_regs
  import upt_pkg::*;
#(
  parameter int OTP_WAIT_CYCLES = UPT_OTP_WAIT_CYCLES
) (
  input wire logic core_clk, // system clock
  input wire logic rst, // async reset, active high
  input wire logic [7:0] reg_addr, // register offset
  input wire logic [7:0] reg_wdata, // write data
  input wire logic reg_wr, // write strobe, one cycle
  input wire logic reg_rd, // read strobe, one cycle
  output logic [7:0] reg_rdata, // read data
  output logic reg_rvalid, // read data valid, one cycle
  output logic reg_ready, // registers accept writes
  input wire logic otp_ready, // factory settings available
  input wire upt_otp_t otp_data, // factory settings and their valid bits
  input wire logic chirp_active, // chirp J or K being driven
  input wire logic connect_announced, // connect announcement by host side
  input wire logic detect_done, // charger detection attempt finished, pulse
  output upt_tune_t tune, // fields to analog
  output logic tx_emphasis_on, // effective legacy emphasis enable
  output logic charger_detect_run, // gated charger detection enable
  output logic pullup_enable // pull-up after detection attempt
);

  // ==========================================================
  // helpers
  function automatic logic [7:0] upt_merge(input logic [7:0] val, input logic [7:0] rw_mask,
                                           input logic [7:0] rst_val);
    upt_merge = (val & rw_mask) | (rst_val & ~rw_mask);
  endfunction : upt_merge

  function automatic logic upt_hit(input logic [7:0] addr, input logic [7:0] ofs);
    upt_hit = (addr == ofs);
  endfunction : upt_hit

  // ==========================================================
  // factory settings loader
  logic load_pulse;
  logic cfg_ready;

  upt_otp_loader #(
    .WAIT_CYCLES(OTP_WAIT_CYCLES)
  ) u_loader (
    .core_clk(core_clk),
    .rst(rst),
    .otp_ready(otp_ready),
    .load_pulse(load_pulse),
    .cfg_ready(cfg_ready)
  );

  // otp data is latched with otp_ready so it is stable when applied
  upt_otp_t otp_reg, otp_next;

  always_comb begin
    otp_next = otp_reg;
    if (otp_ready && !cfg_ready) begin
      otp_next = otp_data;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      otp_reg <= '0;
    end else begin
      otp_reg <= otp_next;
    end
  end

  // ==========================================================
  // register storage
  logic [7:0] ltx_reg, ltx_next;
  logic [7:0] lrx_reg, lrx_next;
  logic [7:0] lthr_reg, lthr_next;
  logic [7:0] etx_reg, etx_next;
  logic wr_ok;

  assign wr_ok = reg_wr && cfg_ready;

  always_comb begin
    ltx_next = ltx_reg;
    lrx_next = lrx_reg;
    lthr_next = lthr_reg;
    etx_next = etx_reg;
    if (load_pulse) begin
      if (otp_reg.valid[UPT_IDX_LTX]) begin
        ltx_next = upt_merge(otp_reg.ltx, UPT_RW_LTX, UPT_RST_LTX);
      end
      if (otp_reg.valid[UPT_IDX_LRX]) begin
        lrx_next = upt_merge(otp_reg.lrx, UPT_RW_LRX, UPT_RST_LRX);
      end
      if (otp_reg.valid[UPT_IDX_LTHR]) begin
        lthr_next = upt_merge(otp_reg.lthr, UPT_RW_LTHR, UPT_RST_LTHR);
      end
      if (otp_reg.valid[UPT_IDX_ETX]) begin
        etx_next = upt_merge(otp_reg.etx, UPT_RW_ETX, UPT_RST_ETX);
      end
    end
    if (wr_ok) begin
      if (upt_hit(reg_addr, UPT_OFS_LTX)) begin
        ltx_next = upt_merge(reg_wdata, UPT_RW_LTX, UPT_RST_LTX);
      end
      if (upt_hit(reg_addr, UPT_OFS_LRX)) begin
        lrx_next = upt_merge(reg_wdata, UPT_RW_LRX, UPT_RST_LRX);
      end
      if (upt_hit(reg_addr, UPT_OFS_LTHR)) begin
        lthr_next = upt_merge(reg_wdata, UPT_RW_LTHR, UPT_RST_LTHR);
      end
      if (upt_hit(reg_addr, UPT_OFS_ETX)) begin
        etx_next = upt_merge(reg_wdata, UPT_RW_ETX, UPT_RST_ETX);
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ltx_reg <= UPT_RST_LTX;
      lrx_reg <= UPT_RST_LRX;
      lthr_reg <= UPT_RST_LTHR;
      etx_reg <= UPT_RST_ETX;
    end else begin
      ltx_reg <= ltx_next;
      lrx_reg <= lrx_next;
      lthr_reg <= lthr_next;
      etx_reg <= etx_next;
    end
  end

  // ==========================================================
  // read port and write ready
  logic [7:0] rdata_reg, rdata_next;
  logic rvalid_reg, rvalid_next;
  logic wready_reg, wready_next;

  always_comb begin
    rdata_next = rdata_reg;
    rvalid_next = reg_rd;
    wready_next = cfg_ready;
    if (reg_rd) begin
      if (upt_hit(reg_addr, UPT_OFS_LTX)) begin
        rdata_next = ltx_reg;
      end else if (upt_hit(reg_addr, UPT_OFS_LRX)) begin
        rdata_next = lrx_reg;
      end else if (upt_hit(reg_addr, UPT_OFS_LTHR)) begin
        rdata_next = lthr_reg;
      end else if (upt_hit(reg_addr, UPT_OFS_ETX)) begin
        rdata_next = etx_reg;
      end else begin
        rdata_next = UPT_RD_UNMAPPED;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rdata_reg <= UPT_RD_UNMAPPED;
      rvalid_reg <= 1'b0;
      wready_reg <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
      wready_reg <= wready_next;
    end
  end

  assign reg_rdata = rdata_reg;
  assign reg_rvalid = rvalid_reg;
  assign reg_ready = wready_reg;

  // ==========================================================
  // field decode to analog
  upt_tune_t tune_reg, tune_next;
  logic [2:0] lvl_raw;

  assign lvl_raw = ltx_reg[UPT_LTX_LVL_LSB +: 3];

  always_comb begin
    tune_next = '0;
    tune_next.charger_advertise_enable = ltx_reg[UPT_LTX_CDP_BIT];
    tune_next.legacy_emphasis_width = ltx_reg[UPT_LTX_WID_LSB +: 2];
    tune_next.legacy_emphasis_enable = ltx_reg[UPT_LTX_EN_BIT];
    tune_next.legacy_emphasis_level = (lvl_raw > UPT_LTX_LVL_MAX) ? UPT_LTX_LVL_MAX : lvl_raw;
    tune_next.legacy_rx_equaliser = lrx_reg[UPT_LRX_EQ_LSB +: 3];
    tune_next.disconnect_level = lthr_reg[UPT_LTHR_DISC_LSB +: 4];
    tune_next.legacy_squelch_level = lthr_reg[UPT_LTHR_SQ_LSB +: 3];
    tune_next.embedded_emphasis_level = etx_reg[UPT_ETX_LVL_LSB +: 3];
    tune_next.embedded_emphasis_width = etx_reg[UPT_ETX_WID_LSB +: 2];
    tune_next.charger_detect_enable = etx_reg[UPT_ETX_BCD_BIT];
  end

  // ==========================================================
  // line-state gating
  logic emph_reg, emph_next;
  logic bcd_run_reg, bcd_run_next;
  logic pullup_reg, pullup_next;

  always_comb begin
    emph_next = ltx_reg[UPT_LTX_EN_BIT] && !chirp_active;
    bcd_run_next = etx_reg[UPT_ETX_BCD_BIT] && connect_announced && !pullup_reg;
    pullup_next = pullup_reg;
    if (!connect_announced) begin
      pullup_next = 1'b0;
    end else if (detect_done && bcd_run_reg) begin
      pullup_next = 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tune_reg <= '0;
      emph_reg <= 1'b0;
      bcd_run_reg <= 1'b0;
      pullup_reg <= 1'b0;
    end else begin
      tune_reg <= tune_next;
      emph_reg <= emph_next;
      bcd_run_reg <= bcd_run_next;
      pullup_reg <= pullup_next;
    end
  end

  assign tune = tune_reg;
  assign tx_emphasis_on = emph_reg;
  assign charger_detect_run = bcd_run_reg;
  assign pullup_enable = pullup_reg;

endmodule : upt_port_tuning_regs
`default_nettype wire

// ### shared/upt_pkg.sv
// Notes on behaviour
// - Factory settings, when offered within the first OTP_WAIT_CYCLES+1 cycles after reset, replace the built-in default of each register whose valid bit is set.
// - The legacy emphasis register sits at 0x71 and resets to 0x3C.
// - Bit 7 of the legacy emphasis register enables charger advertising and resets to zero.
// - Bits 5-4 pick the legacy emphasis pulse width, code 3 after reset.
// - Bit 3 enables legacy emphasis, resets to one, and may be replaced by a factory setting.
// - Emphasis is held off while chirp J or chirp K is driven, whatever the enable bit says; only tx_emphasis_on is gated, tune.legacy_emphasis_enable is not.
// - Bits 2-0 pick the legacy emphasis level, reset 4; codes 6 and 7 are not to be used.
// - The legacy receive register sits at 0x72, resets to 0x92, and bits 7-3 are reserved.
// - Bits 2-0 of the receive register pick one of eight equaliser steps, code 2 after reset.
// - The threshold register sits at 0x73, resets to 0x83, and bit 3 is reserved at zero.
// - Bits 7-4 pick one of sixteen disconnect thresholds, code 8 after reset.
// - Bits 2-0 pick one of eight squelch thresholds, code 3 after reset.
// - The embedded emphasis register sits at 0x77, resets to zero, and may be factory replaced.
// - In the embedded register bits 7-5 set the level and bits 4-3 the width.
// - Bit 0 of the embedded register enables charger detection, gated by connect, then pull-up.
package upt_pkg;

  // ==========================================================
  // register map
  localparam logic [7:0] UPT_OFS_LTX = 8'h71;
  localparam logic [7:0] UPT_OFS_LRX = 8'h72;
  localparam logic [7:0] UPT_OFS_LTHR = 8'h73;
  localparam logic [7:0] UPT_OFS_ETX = 8'h77;

  localparam logic [7:0] UPT_RST_LTX = 8'h3C;
  localparam logic [7:0] UPT_RST_LRX = 8'h92;
  localparam logic [7:0] UPT_RST_LTHR = 8'h83;
  localparam logic [7:0] UPT_RST_ETX = 8'h00;

  // bits that hold state; the rest are reserved and read their reset value
  localparam logic [7:0] UPT_RW_LTX = 8'hBF;
  localparam logic [7:0] UPT_RW_LRX = 8'h07;
  localparam logic [7:0] UPT_RW_LTHR = 8'hF7;
  localparam logic [7:0] UPT_RW_ETX = 8'hF9;

  localparam logic [7:0] UPT_RD_UNMAPPED = 8'h00;

  // ==========================================================
  // field positions
  localparam int UPT_LTX_CDP_BIT = 7;
  localparam int UPT_LTX_WID_LSB = 4;
  localparam int UPT_LTX_EN_BIT = 3;
  localparam int UPT_LTX_LVL_LSB = 0;
  localparam int UPT_LRX_EQ_LSB = 0;
  localparam int UPT_LTHR_DISC_LSB = 4;
  localparam int UPT_LTHR_SQ_LSB = 0;
  localparam int UPT_ETX_LVL_LSB = 5;
  localparam int UPT_ETX_WID_LSB = 3;
  localparam int UPT_ETX_BCD_BIT = 0;

  // highest legacy emphasis level code that is recommended
  localparam logic [2:0] UPT_LTX_LVL_MAX = 3'h5;

  // ==========================================================
  // factory settings loader
  localparam int UPT_NREG = 4;
  localparam int UPT_OTP_WAIT_CYCLES = 64;

  typedef enum logic [1:0] {
    UPT_IDX_LTX,
    UPT_IDX_LRX,
    UPT_IDX_LTHR,
    UPT_IDX_ETX
  } upt_idx_t;

  typedef struct packed {
    logic [UPT_NREG-1:0] valid; // one per register, bit index as upt_idx_t
    logic [7:0] ltx;
    logic [7:0] lrx;
    logic [7:0] lthr;
    logic [7:0] etx;
  } upt_otp_t;

  // decoded fields driving the analog front end
  typedef struct packed {
    logic charger_advertise_enable;
    logic [1:0] legacy_emphasis_width;
    logic legacy_emphasis_enable;
    logic [2:0] legacy_emphasis_level;
    logic [2:0] legacy_rx_equaliser;
    logic [3:0] disconnect_level;
    logic [2:0] legacy_squelch_level;
    logic [2:0] embedded_emphasis_level;
    logic [1:0] embedded_emphasis_width;
    logic charger_detect_enable;
  } upt_tune_t;

endpackage : upt_pkg

// ### logic/upt_otp_loader.sv
`timescale 1ns/10ps
`default_nettype none
module upt_otp_loader
  import upt_pkg::*;
#(
  parameter int WAIT_CYCLES = UPT_OTP_WAIT_CYCLES
) (
  input wire logic core_clk, // system clock
  input wire logic rst, // async reset, active high
  input wire logic otp_ready, // factory settings available
  output logic load_pulse, // one cycle: apply factory settings
  output logic cfg_ready // registers open to software
);

  typedef enum logic [1:0] {
    UPT_LD_WAIT,
    UPT_LD_APPLY,
    UPT_LD_RUN
  } upt_ld_state_t;

  localparam int CW = $clog2(WAIT_CYCLES + 1);
  localparam logic [CW-1:0] WAIT_LAST = CW'(WAIT_CYCLES);

  upt_ld_state_t state_reg, state_next;
  logic [CW-1:0] cnt_reg, cnt_next;
  logic load_reg, load_next;
  logic ready_reg, ready_next;

  // ==========================================================
  // next state
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    load_next = 1'b0;
    ready_next = ready_reg;
    case (state_reg)
      UPT_LD_WAIT: begin
        cnt_next = cnt_reg + CW'(1);
        if (otp_ready) begin
          state_next = UPT_LD_APPLY;
          load_next = 1'b1;
        end else if (cnt_reg == WAIT_LAST) begin
          // no factory data: keep built-in defaults
          state_next = UPT_LD_RUN;
          ready_next = 1'b1;
        end
      end
      UPT_LD_APPLY: begin
        state_next = UPT_LD_RUN;
        ready_next = 1'b1;
      end
      UPT_LD_RUN: begin
        state_next = UPT_LD_RUN;
      end
      default: begin
        state_next = UPT_LD_WAIT;
        ready_next = 1'b0;
      end
    endcase
  end

  // ==========================================================
  // registers
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_reg <= UPT_LD_WAIT;
      cnt_reg <= '0;
      load_reg <= 1'b0;
      ready_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      load_reg <= load_next;
      ready_reg <= ready_next;
    end
  end

  assign load_pulse = load_reg;
  assign cfg_ready = ready_reg;

endmodule : upt_otp_loader
`default_nettype wire

// ### tb/upt_port_tuning_regs_props.sv
`timescale 1ns/10ps
`default_nettype none
module upt_tune_props
  import upt_pkg::*;
#(
  parameter int OTP_WAIT_CYCLES = UPT_OTP_WAIT_CYCLES
) (
  input wire logic core_clk, // system clock
  input wire logic rst, // async reset
  input wire logic [7:0] reg_addr, // offset
  input wire logic reg_rd, // read strobe
  input wire logic [7:0] reg_rdata, // read data
  input wire logic reg_rvalid, // read valid
  input wire logic reg_ready, // open to writes
  input wire logic chirp_active, // chirp driven
  input wire logic connect_announced, // connect
  input wire logic detect_done, // attempt done
  input wire upt_tune_t tune, // decoded fields
  input wire logic tx_emphasis_on, // gated emphasis
  input wire logic charger_detect_run, // gated detection
  input wire logic pullup_enable // pull-up
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // ==========================================================
  // register bus
  rd_answer_a: assert property (reg_rd |=> reg_rvalid)
    else $error("read not answered");
  rvalid_cause_a: assert property (reg_rvalid |-> $past(reg_rd))
    else $error("read answer without read");
  ltx_rsvd_a: assert property (reg_rvalid && $past(reg_addr) == UPT_OFS_LTX |-> !reg_rdata[6])
    else $error("emphasis reserved bit set");
  lrx_rsvd_a: assert property (reg_rvalid && $past(reg_addr) == UPT_OFS_LRX |->
    reg_rdata[7:3] == 5'h12)
    else $error("receive reserved bits wrong");
  lthr_rsvd_a: assert property (reg_rvalid && $past(reg_addr) == UPT_OFS_LTHR |->
    !reg_rdata[3])
    else $error("threshold reserved bit set");
  ready_hold_a: assert property (reg_ready |=> reg_ready)
    else $error("ready dropped");
  // ==========================================================
  // emphasis level limit and line gating
  level_cap_a: assert property (tune.legacy_emphasis_level <= UPT_LTX_LVL_MAX)
    else $error("emphasis level above limit");
  chirp_gate_a: assert property (tx_emphasis_on ==
    (tune.legacy_emphasis_enable && !$past(chirp_active)))
    else $error("emphasis during chirp");
  detect_gate_a: assert property (charger_detect_run |-> tune.charger_detect_enable &&
    $past(connect_announced) && !$past(pullup_enable))
    else $error("detection not gated");
  pullup_set_a: assert property (detect_done && charger_detect_run && connect_announced
    |=> pullup_enable)
    else $error("no pull-up after detection");
endmodule : upt_tune_props

bind upt_port_tuning_regs upt_tune_props #(.OTP_WAIT_CYCLES(OTP_WAIT_CYCLES)) u_props (
  .core_clk, .rst, .reg_addr, .reg_rd, .reg_rdata, .reg_rvalid, .reg_ready, .chirp_active,
  .connect_announced, .detect_done, .tune, .tx_emphasis_on, .charger_detect_run, .pullup_enable
);
`default_nettype wire

// ### tb/upt_port_tuning_regs_tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_total++; \
  $display("[FAIL] %0t got %h exp %h", $time, (g), (e)); end end
module upt_port_tuning_regs_tb
  import upt_pkg::*;
();
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic otp_ready = 1'b0;
  logic chirp_active = 1'b0;
  logic connect_announced = 1'b0;
  logic detect_done = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic reg_rvalid, reg_ready, tx_emphasis_on, charger_detect_run, pullup_enable;
  upt_otp_t otp_data = '0;
  upt_tune_t tune;
  int err_total = 0;
  int n_tests = 0;
  logic [7:0] ofs[4] = '{UPT_OFS_LTX, UPT_OFS_LRX, UPT_OFS_LTHR, UPT_OFS_ETX};
  logic [7:0] rsts[4] = '{UPT_RST_LTX, UPT_RST_LRX, UPT_RST_LTHR, UPT_RST_ETX};
  logic [7:0] ones[4] = '{8'hBF, 8'h97, 8'hF7, 8'hF9};
  logic [7:0] zeros[4] = '{8'h00, 8'h90, 8'h00, 8'h00};

  always #50 core_clk = ~core_clk;

  upt_port_tuning_regs #(.OTP_WAIT_CYCLES(4)) dut (
    .core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .reg_rvalid,
    .reg_ready, .otp_ready, .otp_data, .chirp_active, .connect_announced, .detect_done,
    .tune, .tx_emphasis_on, .charger_detect_run, .pullup_enable
  );

  // ==========================================================
  // bus tasks
  task automatic conclude();
    $display("checks %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : conclude

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #5;
  endtask : tick

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    tick(1);
    reg_wr = 1'b0;
    tick(1);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    reg_addr = a;
    reg_rd = 1'b1;
    tick(1);
    reg_rd = 1'b0;
    `CHK(reg_rvalid, 1'b1)
    `CHK(reg_rdata, e)
    tick(1);
  endtask : rd

  task automatic wait_ready();
    for (int i = 0; i < 20 && reg_ready !== 1'b1; i++) tick(1);
    if (reg_ready !== 1'b1) begin
      err_total++;
      $display("[FAIL] %0t ready timeout", $time);
      conclude();
    end
  endtask : wait_ready

  // ==========================================================
  // sequence
  initial begin
    tick(4);
    rst = 1'b0;
    tick(1);
    `CHK(tune, {1'b0, 2'h3, 1'b1, 3'h4, 3'h2, 4'h8, 3'h3, 3'h0, 2'h0, 1'b0})
    `CHK(reg_ready, 1'b0)
    // early write lands before ready and is dropped
    wr(UPT_OFS_LTX, 8'hFF);
    for (int i = 0; i < 4; i++) rd(ofs[i], rsts[i]);
    wait_ready();
    for (int i = 0; i < 4; i++) begin
      wr(ofs[i], 8'hFF);
      rd(ofs[i], ones[i]);
      wr(ofs[i], 8'h00);
      rd(ofs[i], zeros[i]);
    end
    wr(8'h74, 8'h5A);
    rd(8'h74, UPT_RD_UNMAPPED);
    wr(UPT_OFS_LTX, 8'h0F);
    rd(UPT_OFS_LTX, 8'h0F);
    `CHK(tune.legacy_emphasis_level, UPT_LTX_LVL_MAX)
    `CHK(tx_emphasis_on, 1'b1)
    chirp_active = 1'b1;
    tick(1);
    `CHK(tx_emphasis_on, 1'b0)
    chirp_active = 1'b0;
    tick(1);
    `CHK(tx_emphasis_on, 1'b1)
    wr(UPT_OFS_ETX, 8'h01);
    `CHK(charger_detect_run, 1'b0)
    connect_announced = 1'b1;
    tick(1);
    `CHK(charger_detect_run, 1'b1)
    detect_done = 1'b1;
    tick(1);
    detect_done = 1'b0;
    `CHK(pullup_enable, 1'b1)
    tick(1);
    `CHK(charger_detect_run, 1'b0)
    connect_announced = 1'b0;
    tick(1);
    `CHK(pullup_enable, 1'b0)
    // second reset with factory data for three registers
    rst = 1'b1;
    otp_ready = 1'b1;
    otp_data = '{valid: 4'hD, ltx: 8'hC5, lrx: 8'h00, lthr: 8'h11, etx: 8'hFF};
    tick(4);
    rst = 1'b0;
    wait_ready();
    rd(UPT_OFS_LTX, 8'h85);
    rd(UPT_OFS_LRX, UPT_RST_LRX);
    rd(UPT_OFS_LTHR, 8'h11);
    rd(UPT_OFS_ETX, 8'hF9);
    `CHK(tune, {1'b1, 2'h0, 1'b0, 3'h5, 3'h2, 4'h1, 3'h1, 3'h7, 2'h3, 1'b1})
    wr(UPT_OFS_ETX, 8'hA8);
    `CHK(tune.embedded_emphasis_level, 3'h5)
    `CHK(tune.embedded_emphasis_width, 2'h1)
    conclude();
  end
endmodule : upt_port_tuning_regs_tb
`default_nettype wire
